// File: hrt_pkg.sv
`default_nettype none
package hrt_pkg;

    // Register byte offsets on the APB port.
    localparam logic [7:0] ADDR_CTL0   = 8'h00;
    localparam logic [7:0] ADDR_CTL1   = 8'h04;
    localparam logic [7:0] ADDR_COUNT  = 8'h08;
    localparam logic [7:0] ADDR_PERIOD = 8'h0C;
    localparam logic [7:0] ADDR_HCTL0  = 8'h10;
    localparam logic [7:0] ADDR_HCTL1  = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // Count mode codes.
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_UP   = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [1:0] MODE_UPDN = 2'h3;

    // Timer clock mode codes.
    localparam logic [1:0] CLKM_INPUT = 2'h0;
    localparam logic [1:0] CLKM_HIRES = 2'h1;
    localparam logic [1:0] CLKM_AUX   = 2'h2;

    // Counter length codes and their maximum counts.
    localparam logic [1:0]  LEN_16 = 2'h0;
    localparam logic [1:0]  LEN_12 = 2'h1;
    localparam logic [1:0]  LEN_10 = 2'h2;
    localparam logic [1:0]  LEN_8  = 2'h3;
    localparam logic [15:0] MAX_16 = 16'hFFFF;
    localparam logic [15:0] MAX_12 = 16'h0FFF;
    localparam logic [15:0] MAX_10 = 16'h03FF;
    localparam logic [15:0] MAX_8  = 16'h00FF;

    // Generator constants: trim midpoint offset and per-input-clock event counts.
    localparam logic [8:0]  TRIM_BIAS  = 9'h0C0;
    localparam logic [15:0] MULT_8X    = 16'h0008;
    localparam logic [15:0] MULT_16X   = 16'h0010;
    localparam logic [1:0]  HMUL_8X    = 2'h0;

    // Reset value of every register.
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Control register zero layout.
    typedef struct packed {
        logic [21:0] unused;
        logic [1:0]  length;
        logic        unused_b;
        logic        clear;
        logic [1:0]  mode;
        logic [1:0]  div1;
        logic [1:0]  src;
    } hrt_ctl0_type;

    // Control register one layout.
    typedef struct packed {
        logic [25:0] unused;
        logic        ovf_ie;
        logic [2:0]  div2;
        logic [1:0]  clkmode;
    } hrt_ctl1_type;

    // Generator control zero layout.
    typedef struct packed {
        logic [27:0] unused;
        logic [1:0]  mult;
        logic        regen;
        logic        enable;
    } hrt_hctl0_type;

    // Generator control one layout.
    typedef struct packed {
        logic [16:0] unused;
        logic        coarse;
        logic [1:0]  range;
        logic [4:0]  subrange;
        logic [6:0]  trim;
    } hrt_hctl1_type;

    // Whole state of the timer core.
    typedef struct packed {
        hrt_ctl0_type  ctl0;
        hrt_ctl1_type  ctl1;
        hrt_hctl0_type hctl0;
        hrt_hctl1_type hctl1;
        logic [15:0]   count;
        logic [15:0]   period;
        logic          ovf_flag;
        logic          ccr0_flag;
        logic          ch0_out;
        logic          odd_event;
        logic          down;
        logic [2:0]    div1_cnt;
        logic [2:0]    div2_cnt;
        logic [17:0]   hr_phase;
        logic [15:0]   reg_period;
        logic [15:0]   reg_meas;
        logic [15:0]   reg_phase;
        logic [31:0]   prdata;
        logic          pslverr;
    } hrt_state_type;

endpackage
`default_nettype wire

// File: hrt_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module hrt_edge_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rst,
    // Asynchronous pins.
    input  wire logic [WIDTH-1:0] pin,
    // Synchronised level and one-cycle rising-edge pulse.
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] last;
    } hrt_sync_type;

    hrt_sync_type s_reg;
    hrt_sync_type s_next;

    // The first stage feeds only the second; edges are taken after it.
    always_comb
    begin
        s_next.meta = pin;
        s_next.sync = s_reg.meta;
        s_next.last = s_reg.sync;
    end

    // State register.
    always_ff @(posedge clock)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    // Outputs come straight from the second and third stages.
    assign level = s_reg.sync;
    assign rise  = s_reg.sync & ~s_reg.last;

endmodule
`default_nettype wire

// File: hrt_timer_core.sv
`timescale 1ns/10ps
`default_nettype none
module hrt_timer_core #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  rst,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Clock source pins.
    input  wire logic                  aux_system_clock,
    input  wire logic                  submain_system_clock,
    input  wire logic                  external_timer_clock_input,
    input  wire logic                  alternate_clock_input,
    input  wire logic                  sibling_aux_clock,
    // Event pins.
    input  wire logic                  external_clear_signal,
    input  wire logic                  channel_event,
    // Outputs.
    output logic      [15:0]           timer_count,
    output logic                       channel_zero_output,
    output logic                       odd_channel_event,
    output logic                       overflow_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [6:0] pin_lvl;
    logic [6:0] pin_rise;

    hrt_edge_sync #(
        .WIDTH (7)
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .pin   ({channel_event, external_clear_signal, sibling_aux_clock,
                 alternate_clock_input, external_timer_clock_input,
                 submain_system_clock, aux_system_clock}),
        .level (pin_lvl),
        .rise  (pin_rise)
    );

    hrt_pkg::hrt_state_type s_reg;
    hrt_pkg::hrt_state_type s_next;

    ////////////////////////////////////////////////////////////////////////
    // Combinational next state.

    logic [7:0]  addr;
    logic        wr;
    logic        src_tick;
    logic        div_restart;
    logic        stage1_tick;
    logic        div_tick;
    logic        hr_tick;
    logic        tmr_tick;
    logic        clear_evt;
    logic [15:0] maxv;
    logic [15:0] top;
    logic [15:0] nxt;
    logic        ovf_set;
    logic        match_set;
    logic [2:0]  r1;
    logic [15:0] step_base;
    logic [15:0] prod;
    logic [17:0] step18;
    logic [18:0] hr_sum;
    logic [15:0] mult;
    logic [15:0] reg_sum;
    hrt_pkg::hrt_ctl0_type wr_ctl0;

    always_comb
    begin
        s_next = s_reg;
        addr   = 8'(paddr);
        wr     = psel & penable & pwrite;

        case (s_reg.ctl0.length)
            hrt_pkg::LEN_16: maxv = hrt_pkg::MAX_16;
            hrt_pkg::LEN_12: maxv = hrt_pkg::MAX_12;
            hrt_pkg::LEN_10: maxv = hrt_pkg::MAX_10;
            default:         maxv = hrt_pkg::MAX_8;
        endcase

        wr_ctl0   = pwdata;
        clear_evt = pin_lvl[5] |
                    (wr && addr == hrt_pkg::ADDR_CTL0 && wr_ctl0.clear);

        src_tick = pin_rise[s_reg.ctl0.src];

        div_restart = clear_evt | (s_reg.ctl1.clkmode == hrt_pkg::CLKM_HIRES);

        // two divider stages: first 1/2/4/8, second 1 to 8.
        r1          = 3'((4'h1 << s_reg.ctl0.div1) - 4'h1);
        stage1_tick = 1'b0;
        div_tick    = 1'b0;
        if (div_restart)
        begin
            s_next.div1_cnt = 3'h0;
            s_next.div2_cnt = 3'h0;
        end
        else if (src_tick)
        begin
            if (s_reg.div1_cnt >= r1)
            begin
                s_next.div1_cnt = 3'h0;
                stage1_tick     = 1'b1;
            end
            else
                s_next.div1_cnt = s_reg.div1_cnt + 3'h1;
        end
        if (stage1_tick)
        begin
            if (s_reg.div2_cnt >= s_reg.ctl1.div2)
            begin
                s_next.div2_cnt = 3'h0;
                div_tick        = 1'b1;
            end
            else
                s_next.div2_cnt = s_reg.div2_cnt + 3'h1;
        end

        // free-running rate: (range,subrange) scaled by trim+192.
        // Trim 0 gives -25 percent and 127 gives +24.6 percent around 64.
        step_base = 16'({s_reg.hctl1.range, s_reg.hctl1.subrange}) + 16'h0001;
        prod      = 16'(step_base * 16'(hrt_pkg::TRIM_BIAS + 9'(s_reg.hctl1.trim)));
        step18    = s_reg.hctl1.coarse ? {prod, 2'h0} : {2'h0, prod};
        hr_sum    = {1'b0, s_reg.hr_phase} + {1'b0, step18};

        // regulated: measure input period, emit mult events per period.
        // At most one event per system clock, so short input periods saturate.
        mult    = (s_reg.hctl0.mult == hrt_pkg::HMUL_8X) ? hrt_pkg::MULT_8X
                                                         : hrt_pkg::MULT_16X;
        reg_sum = s_reg.reg_phase + mult;
        if (src_tick)
        begin
            s_next.reg_period = s_reg.reg_meas + 16'h0001;
            s_next.reg_meas   = 16'h0000;
        end
        else if (s_reg.reg_meas != 16'hFFFF)
            s_next.reg_meas = s_reg.reg_meas + 16'h0001;

        hr_tick = 1'b0;
        if (!s_reg.hctl0.enable)
        begin
            s_next.hr_phase  = 18'h0;
            s_next.reg_phase = 16'h0;
        end
        else if (s_reg.hctl0.regen)
        begin
            if (s_reg.reg_period != 16'h0000 && reg_sum >= s_reg.reg_period)
            begin
                s_next.reg_phase = reg_sum - s_reg.reg_period;
                hr_tick          = 1'b1;
            end
            else
                s_next.reg_phase = reg_sum;
        end
        else
        begin
            s_next.hr_phase = hr_sum[17:0];
            hr_tick         = hr_sum[18];
        end

        case (s_reg.ctl1.clkmode)
            hrt_pkg::CLKM_INPUT: tmr_tick = div_tick;
            hrt_pkg::CLKM_HIRES: tmr_tick = hr_tick;
            hrt_pkg::CLKM_AUX:   tmr_tick = pin_rise[4];
            default:             tmr_tick = 1'b0;
        endcase

        // count modes; the turn value is the period except in continuous.
        top       = (s_reg.ctl0.mode == hrt_pkg::MODE_CONT) ? maxv
                                                            : (s_reg.period & maxv);
        nxt       = s_reg.count;
        ovf_set   = 1'b0;
        match_set = 1'b0;
        if (tmr_tick && s_reg.ctl0.mode != hrt_pkg::MODE_STOP)
        begin
            if (s_reg.ctl0.mode == hrt_pkg::MODE_UPDN && s_reg.down)
            begin
                if (s_reg.count <= 16'h0001)
                begin
                    nxt           = 16'h0000;
                    s_next.down   = 1'b0;
                    ovf_set       = (s_reg.count == 16'h0001);
                end
                else
                    nxt = s_reg.count - 16'h0001;
            end
            else if (s_reg.count >= top)
            begin
                if (s_reg.ctl0.mode == hrt_pkg::MODE_UPDN && top != 16'h0000)
                begin
                    nxt         = s_reg.count - 16'h0001;
                    s_next.down = 1'b1;
                end
                else
                begin
                    // wrap from terminal value to zero
                    nxt     = 16'h0000;
                    ovf_set = (s_reg.count == top);
                end
            end
            else
            begin
                nxt       = s_reg.count + 16'h0001;
                match_set = (nxt == (s_reg.period & maxv));
            end
        end
        s_next.count = nxt & maxv;

        // channel zero output: match sets, overflow or the external clear pin resets.
        if (pin_lvl[5] | ovf_set)
            s_next.ch0_out = 1'b0;
        else if (match_set)
            s_next.ch0_out = 1'b1;

        // odd channel event with external clear
        s_next.odd_event = pin_lvl[6] | pin_lvl[5];

        // Register writes; flags clear on one but a same-cycle set wins.
        if (wr)
        begin
            case (addr)
                hrt_pkg::ADDR_CTL0:
                begin
                    s_next.ctl0        = pwdata;
                    s_next.ctl0.unused = '0;
                    s_next.ctl0.unused_b = 1'b0;
                    s_next.ctl0.clear  = 1'b0;
                end
                hrt_pkg::ADDR_CTL1:
                begin
                    s_next.ctl1        = pwdata;
                    s_next.ctl1.unused = '0;
                end
                hrt_pkg::ADDR_COUNT:
                begin
                    s_next.count = pwdata[15:0] & maxv;
                    s_next.down  = 1'b0;
                end
                hrt_pkg::ADDR_PERIOD: s_next.period = pwdata[15:0];
                hrt_pkg::ADDR_HCTL0:
                begin
                    s_next.hctl0        = pwdata;
                    s_next.hctl0.unused = '0;
                end
                hrt_pkg::ADDR_HCTL1:
                begin
                    s_next.hctl1        = pwdata;
                    s_next.hctl1.unused = '0;
                end
                hrt_pkg::ADDR_STATUS:
                begin
                    if (pwdata[0])
                        s_next.ovf_flag = 1'b0;
                    if (pwdata[1])
                        s_next.ccr0_flag = 1'b0;
                end
                default: ;
            endcase
        end
        if (ovf_set)
            s_next.ovf_flag = 1'b1;
        if (match_set)
            s_next.ccr0_flag = 1'b1;

        if (clear_evt)
        begin
            s_next.count = 16'h0000;
            s_next.down  = 1'b0;
        end

        // Read data is captured in the setup cycle so prdata is a flop.
        if (psel && !penable)
        begin
            s_next.pslverr = 1'b0;
            case (addr)
                hrt_pkg::ADDR_CTL0:   s_next.prdata = s_reg.ctl0;
                hrt_pkg::ADDR_CTL1:   s_next.prdata = s_reg.ctl1;
                hrt_pkg::ADDR_COUNT:  s_next.prdata = {16'h0000, s_reg.count};
                hrt_pkg::ADDR_PERIOD: s_next.prdata = {16'h0000, s_reg.period};
                hrt_pkg::ADDR_HCTL0:  s_next.prdata = s_reg.hctl0;
                hrt_pkg::ADDR_HCTL1:  s_next.prdata = s_reg.hctl1;
                hrt_pkg::ADDR_STATUS: s_next.prdata = {29'h0, s_reg.ch0_out,
                                                       s_reg.ccr0_flag, s_reg.ovf_flag};
                default:
                begin
                    s_next.prdata  = 32'h0000_0000;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clock)
    begin
        if (rst)
            s_reg <= hrt_pkg::hrt_state_type'(0);
        else
            s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Zero wait states: every access phase completes at once.
    assign pready              = psel & penable;
    assign pslverr             = psel & penable & s_reg.pslverr;
    assign prdata              = s_reg.prdata;
    assign timer_count         = s_reg.count;
    assign channel_zero_output = s_reg.ch0_out;
    assign odd_channel_event   = s_reg.odd_event;
    assign overflow_irq        = s_reg.ovf_flag & s_reg.ctl1.ovf_ie;

endmodule
`default_nettype wire

// File: hrt_timer_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module hrt_timer_core_asserts #(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset.
    input wire logic                  clock,
    input wire logic                  rst,
    // APB slave.
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Event pins and outputs.
    input wire logic                  external_clear_signal,
    input wire logic                  channel_event,
    input wire logic [15:0]           timer_count,
    input wire logic                  channel_zero_output,
    input wire logic                  odd_channel_event,
    input wire logic                  overflow_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Access phase of any transfer.
    logic acc;
    assign acc = psel && penable;
    // Steps shared by several properties.
    sequence s_wr(a);
        acc && pwrite && paddr == a;
    endsequence
    sequence s_quiet;
        !external_clear_signal [*4];
    endsequence
    // Bus answers and refusals.
    property p_ready;
        pready == acc;
    endproperty
    property p_unmapped;
        acc && paddr > 8'h18 |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    // The sync stages give the clear pin a few cycles of latency, hence five.
    property p_ext_clear;
        external_clear_signal [*5] |-> timer_count == 16'h0000;
    endproperty
    property p_write_now;
        s_quiet ##0 s_wr(hrt_pkg::ADDR_COUNT) |=>
            (timer_count & ~$past(pwdata[15:0])) == 16'h0000;
    endproperty
    // Overflow and channel zero only come from real counting; the odd event follows its pins.
    property p_ovf_wrap;
        $rose(overflow_irq) && !$past(acc && pwrite && paddr == hrt_pkg::ADDR_CTL1)
            |-> timer_count == 16'h0000;
    endproperty
    property p_ch0_fall;
        $fell(channel_zero_output) |-> timer_count == 16'h0000;
    endproperty
    property p_ch0_set;
        s_wr(hrt_pkg::ADDR_COUNT) |=> !$rose(channel_zero_output);
    endproperty
    property p_odd_on;
        (channel_event || external_clear_signal) [*5] |-> odd_channel_event;
    endproperty
    property p_odd_off;
        (!channel_event && !external_clear_signal) [*5] |-> !odd_channel_event;
    endproperty
    a_ready: assert property (p_ready) else $error("pready wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access");
    a_ext_clear: assert property (p_ext_clear) else $error("clear missed");
    a_write_now: assert property (p_write_now) else $error("count write late");
    a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow off wrap");
    a_ch0_fall: assert property (p_ch0_fall) else $error("ch0 reset wrong");
    a_ch0_set: assert property (p_ch0_set) else $error("ch0 set by write");
    a_odd_on: assert property (p_odd_on) else $error("odd event low");
    a_odd_off: assert property (p_odd_off) else $error("odd event high");
endmodule
bind hrt_timer_core hrt_timer_core_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) i_hrt_timer_core_asserts (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clear_signal(external_clear_signal), .channel_event(channel_event),
    .timer_count(timer_count), .channel_zero_output(channel_zero_output),
    .odd_channel_event(odd_channel_event), .overflow_irq(overflow_irq));
`default_nettype wire

// File: hrt_timer_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module hrt_timer_core_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0]  pins = 5'h00;
    logic        ext_clr = 1'b0;
    logic        ch_evt = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [15:0] cnt;
    logic        pready;
    logic        pslverr;
    logic        er;
    logic        ch0;
    logic        odd;
    logic        irq;
    int          n_fail = 0;
    int          checks = 0;
    int          p;
    int          k;
    int          r;
    // Free-running clock.
    always #12.5 clock = ~clock;
    hrt_timer_core #(.ADDR_WIDTH(8)) i_hrt_timer_core (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .aux_system_clock(pins[0]), .submain_system_clock(pins[1]),
        .external_timer_clock_input(pins[2]), .alternate_clock_input(pins[3]),
        .sibling_aux_clock(pins[4]), .external_clear_signal(ext_clr), .channel_event(ch_evt),
        .timer_count(cnt), .channel_zero_output(ch0), .odd_channel_event(odd),
        .overflow_irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run.
    task automatic results();
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Case equality, so an unknown never matches.
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex)
        begin
            $display("ERROR %s expected %h seen %h", nm, ex, got);
            n_fail++;
        end
    endtask
    // Window check for rates that have no exact phase.
    task automatic chk_in(input string nm, input int lo, input int hi, input logic [31:0] got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
            n_fail++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pin edges must stay slow against the sync stages.
    task automatic pulse(input int idx, input int n, input int half);
        repeat (n)
        begin
            @(posedge clock);
            pins[idx] <= 1'b1;
            wt(half);
            pins[idx] <= 1'b0;
            wt(half - 1);
        end
        wt(6);
    endtask
    // Configure, clear the count and drop stale flags.
    task automatic setup(input logic [1:0] src, d1, md, len, ck, input logic [2:0] d2);
        apb(1'b1, hrt_pkg::ADDR_CTL1, {26'h0, 1'b1, d2, ck});
        apb(1'b1, hrt_pkg::ADDR_CTL0, {22'h0, len, 2'b01, md, d1, src});
        apb(1'b1, hrt_pkg::ADDR_STATUS, 32'h3);
    endtask
    task automatic rdc(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [15:0] max_of(input int l);
        return 16'hFFFF >> ((l == 0) ? 0 : 2 * l + 2);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        void'($urandom(32'h6a08));
        wt(5);
        rst <= 1'b0;
        for (int a = 0; a < 7; a++)
        begin
            rdc(8'(a * 4));
            chk("reset", hrt_pkg::RESET_WORD, rd);
        end
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C);
        chk("unmapped", 32'h1, {rd[30:0], er});
        for (int s = 0; s < 5; s++)
        begin
            k = $urandom_range(20, 1);
            setup(2'(s % 4), 2'h0, hrt_pkg::MODE_CONT, hrt_pkg::LEN_16,
                  (s == 4) ? hrt_pkg::CLKM_AUX : hrt_pkg::CLKM_INPUT, 3'h0);
            pulse(s, k, 3);
            pulse((s + 1) % 5, 3, 3);
            rdc(hrt_pkg::ADDR_COUNT);
            chk("source", 32'(k), rd);
        end
        // A clear part way through a divide period restarts the chain.
        for (int d = 0; d < 4; d++)
        begin
            r = $urandom_range(7, 0);
            p = (1 << d) * (r + 1);
            k = $urandom_range(3, 1);
            setup(2'h1, 2'(d), hrt_pkg::MODE_CONT, hrt_pkg::LEN_16, hrt_pkg::CLKM_INPUT, 3'(r));
            pulse(1, p - 1, 3);
            apb(1'b1, hrt_pkg::ADDR_CTL0, {24'h0, 2'b01, hrt_pkg::MODE_CONT, 2'(d), 2'h1});
            pulse(1, p * k, 3);
            rdc(hrt_pkg::ADDR_COUNT);
            chk("divider", 32'(k), rd);
        end
        for (int l = 0; l < 4; l++)
        begin
            setup(2'h1, 2'h0, hrt_pkg::MODE_CONT, 2'(l), hrt_pkg::CLKM_INPUT, 3'h0);
            apb(1'b1, hrt_pkg::ADDR_PERIOD, 32'h10);
            apb(1'b1, hrt_pkg::ADDR_COUNT, 32'hFFFF);
            rdc(hrt_pkg::ADDR_COUNT);
            chk("length", {16'h0, max_of(l)}, rd);
            pulse(1, 1, 3);
            rdc(hrt_pkg::ADDR_STATUS);
            chk("wrap", 32'h1, {cnt, rd[15:0]});
            chk("irq", 32'h1, {31'h0, irq});
        end
        apb(1'b1, hrt_pkg::ADDR_STATUS, 32'h1);
        rdc(hrt_pkg::ADDR_STATUS);
        chk("w1c", 32'h0, rd);
        setup(2'h1, 2'h0, hrt_pkg::MODE_STOP, hrt_pkg::LEN_16, hrt_pkg::CLKM_INPUT, 3'h0);
        apb(1'b1, hrt_pkg::ADDR_PERIOD, 32'h5);
        apb(1'b1, hrt_pkg::ADDR_COUNT, 32'h5);
        pulse(1, 3, 3);
        rdc(hrt_pkg::ADDR_STATUS);
        chk("stop", {16'h5, 16'h0}, {cnt, rd[15:0]});
        p = $urandom_range(9, 2);
        setup(2'h1, 2'h0, hrt_pkg::MODE_UP, hrt_pkg::LEN_16, hrt_pkg::CLKM_INPUT, 3'h0);
        apb(1'b1, hrt_pkg::ADDR_PERIOD, 32'(p));
        pulse(1, p, 3);
        rdc(hrt_pkg::ADDR_STATUS);
        chk("up", {16'(p), 16'h6}, {cnt, rd[15:0]});
        chk("ch0", 32'h1, {31'h0, ch0});
        pulse(1, 1, 3);
        rdc(hrt_pkg::ADDR_STATUS);
        chk("up_wrap", 32'h3, rd);
        setup(2'h1, 2'h0, hrt_pkg::MODE_UPDN, hrt_pkg::LEN_16, hrt_pkg::CLKM_INPUT, 3'h0);
        pulse(1, p + 2, 3);
        chk("updown", 32'(p - 2), {16'h0, cnt});
        pulse(1, p - 2, 3);
        rdc(hrt_pkg::ADDR_STATUS);
        chk("updown_end", 32'h3, rd);
        // The clear pin wins over a write made while it is high.
        apb(1'b1, hrt_pkg::ADDR_COUNT, 32'h1234);
        ext_clr <= 1'b1;
        wt(5);
        apb(1'b1, hrt_pkg::ADDR_COUNT, 32'h55);
        rdc(hrt_pkg::ADDR_COUNT);
        chk("ext_clear", 32'h0, rd);
        for (int c = 0; c < 4; c++)
        begin
            ch_evt <= c[0];
            ext_clr <= c[1];
            wt(6);
            chk("odd", {31'h0, c[0] | c[1]}, {31'h0, odd});
        end
        ch_evt <= 1'b0;
        ext_clr <= 1'b0;
        wt(6);
        r = $urandom_range(127, 0);
        k = $urandom_range(1, 0);
        apb(1'b1, hrt_pkg::ADDR_HCTL1, {17'h0, k[0], 2'h3, 5'h1F, 7'(r)});
        apb(1'b1, hrt_pkg::ADDR_HCTL0, 32'h1);
        setup(2'h1, 2'h0, hrt_pkg::MODE_CONT, hrt_pkg::LEN_16, hrt_pkg::CLKM_HIRES, 3'h0);
        wt(800);
        rdc(hrt_pkg::ADDR_COUNT);
        p = (805 * 128 * (r + 192) * ((k == 1) ? 4 : 1)) >> 18;
        chk_in("free_run", p - 3, p + 3, rd);
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, hrt_pkg::ADDR_HCTL0, 32'h0);
            apb(1'b1, hrt_pkg::ADDR_HCTL0, {28'h0, 2'(m), 2'b11});
            // Lock onto the input period first so the measured run starts settled.
            pulse(1, 3, 10);
            setup(2'h1, 2'h0, hrt_pkg::MODE_CONT, hrt_pkg::LEN_16, hrt_pkg::CLKM_HIRES, 3'h0);
            pulse(1, 10, 10);
            rdc(hrt_pkg::ADDR_COUNT);
            k = 8 << m;
            chk_in("regulated", k * 6, k * 11, rd);
        end
        results();
    end
    // Watchdog well beyond the expected run length.
    initial
    begin
        wt(40000);
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
